//--- src/ldl_pin_sync.sv
module ldl_pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk,
	input  wire logic             i_sys_rst,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_level,
	output logic      [WIDTH-1:0] o_rise
);
	import ldl_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Stage one is seen only by stage two; stage three keeps the edge detector off it
	typedef struct packed {
		logic [WIDTH-1:0] s1; // Metastability catcher
		logic [WIDTH-1:0] s2; // Settled level
		logic [WIDTH-1:0] s3; // Previous settled level
	} ldl_sync_s;

	ldl_sync_s q; // Registered state
	ldl_sync_s d; // Next state

	// Shift the samples along; reset parks every lane low
	always_comb begin
		d    = q;
		d.s1 = i_async;
		d.s2 = q.s1;
		d.s3 = q.s2;
		if (i_sys_rst) begin
			d = '0;
		end
	end

	// State register
	always_ff @(posedge i_clk) begin
		q <= d;
	end

	assign o_level = q.s2;
	assign o_rise  = q.s2 & ~q.s3;

endmodule : ldl_pin_sync

//--- src/ldl_pkg.sv
package ldl_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Frame and latch geometry
	localparam int COMMON_W     = 288; // Common serial shift register
	localparam int COR_W        = 216; // Correction shift register and latch
	localparam int CHANNELS     = 24;  // Constant-current outputs
	localparam int GROUPS       = 3;   // Red, green and blue groups
	localparam int GS_W         = 12;  // Grayscale value per output
	localparam int DOT_W        = 7;   // Correction value per output
	localparam int BRIGHTNESS_FIELD_W     = 8;   // Brightness per group
	localparam int FUNCTION_FIELD_W       = 7;   // Function bits
	localparam int USER_W       = 17;  // User bits

	// Field positions inside the correction latch
	localparam int DOT_LSB      = 0;
	localparam int BRIGHTNESS_FIELD_LSB   = 168;
	localparam int FUNCTION_FIELD_LSB     = 192;
	localparam int RANGE_LSB    = 192; // Red, green, blue range at 192, 193, 194
	localparam int USER_LSB     = 199;
	localparam int COR_COPY_TOP = 198; // Highest latch bit written from the common path

	// Correction latch contents are loaded here for read-back on the serial output
	localparam int READBACK_LSB = COMMON_W - COR_W;

	////////////////////////////////////////////////////////////////////////////////
	// Timing of the automatic correction transfer
	localparam int CLK_PERIOD_NS = 10;
	localparam int XFER_MIN_MS   = 3;
	localparam int XFER_MAX_MS   = 7;
	localparam int NS_PER_MS     = 1000000;
	localparam int XFER_MIN_CYC  = (XFER_MIN_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int XFER_MAX_CYC  = (XFER_MAX_MS * NS_PER_MS) / CLK_PERIOD_NS;
	localparam int XFER_DEF_CYC  = (XFER_MIN_CYC + XFER_MAX_CYC) / 2;
	localparam int XFER_CNT_W    = 20; // Holds counts up to XFER_MAX_CYC

	////////////////////////////////////////////////////////////////////////////////
	// Synchroniser lanes for the pins
	localparam int PIN_N         = 6;
	localparam int PIN_PWM_CLK   = 0;
	localparam int PIN_PWM_IN    = 1;
	localparam int PIN_STROBE    = 2;
	localparam int PIN_COR_CLK   = 3;
	localparam int PIN_COR_IN    = 4;
	localparam int PIN_BLANK_N   = 5;

	////////////////////////////////////////////////////////////////////////////////
	// Types
	typedef logic [GS_W-1:0]        ldl_gs_t;
	typedef ldl_gs_t [CHANNELS-1:0] ldl_gs_arr_t;
	typedef logic [DOT_W-1:0]       ldl_dot_t;
	typedef ldl_dot_t [CHANNELS-1:0] ldl_dot_arr_t;
	typedef logic [BRIGHTNESS_FIELD_W-1:0]    ldl_brightness_field_t;
	typedef ldl_brightness_field_t [GROUPS-1:0] ldl_brightness_field_arr_t;

	// Correction transfer timer
	typedef enum logic {
		XFER_IDLE = 1'b0,
		XFER_WAIT = 1'b1
	} ldl_xfer_e;

	typedef struct packed {
		logic [COMMON_W-1:0]   common;    // Common serial shift register
		logic [COMMON_W-1:0]   gs_latch;  // Grayscale latch
		logic [COR_W-1:0]      cor_shift; // Correction shift register
		logic [COR_W-1:0]      cor_latch; // Correction/brightness/function/user latch
		logic                  strobe_at_clk; // Strobe level at the last serial clock edge
		ldl_xfer_e             xfer;      // Transfer timer state
		logic [XFER_CNT_W-1:0] cnt;       // Cycles since the last correction clock edge; stops at CNT_LAST
		logic                  xfer_pulse; // One cycle after an automatic transfer
	} ldl_state_s;

endpackage : ldl_pkg

//--- src/ldl_serial_latches.sv
// Function
// - Shift serial input into common register LSB
// - Strobe low at clock: latch grayscale frame
// - Strobe high at clock: latch correction bits
// - Grayscale latch maps 12 bits per output
// - New grayscale values take effect immediately
// - Blanking low forces all outputs off
// - Shift correction input into correction register
// - Correction latch holds correction, brightness, function
// - Correction latch readable on grayscale serial output
// - Shift registers and latches have no reset
// - Automatic correction transfer 3 to 7 ms
// - Function bits choose correction range per group
module ldl_serial_latches #(
	parameter int unsigned CORR_XFER_CYCLES = ldl_pkg::XFER_DEF_CYC
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_sys_rst,
	input  wire logic                   i_pwm_serial_clock,
	input  wire logic                   i_pwm_serial_in,
	input  wire logic                   i_pwm_latch_strobe,
	input  wire logic                   i_correction_serial_clock,
	input  wire logic                   i_correction_serial_in,
	input  wire logic                   i_output_blank_n,
	output logic                        o_pwm_serial_out,
	output logic                        o_correction_serial_out,
	output ldl_pkg::ldl_gs_arr_t        o_grayscale_value,
	output ldl_pkg::ldl_dot_arr_t       o_per_output_correction,
	output ldl_pkg::ldl_brightness_field_arr_t    o_group_brightness,
	output logic [ldl_pkg::FUNCTION_FIELD_W-1:0]  o_function_bits,
	output logic [ldl_pkg::USER_W-1:0]  o_user_bits,
	output logic [ldl_pkg::GROUPS-1:0]  o_correction_range,
	output logic                        o_outputs_on,
	output logic                        o_correction_updated
);
	import ldl_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Constants and decode helpers

	// Last count of the transfer timer, sized to the counter
	localparam logic [XFER_CNT_W-1:0] CNT_LAST = XFER_CNT_W'(CORR_XFER_CYCLES - 1);
	// A delay of zero would wrap this to all ones and stretch the wait to the counter's
	// full range, so the delay must be at least one cycle

	// Grayscale value of one channel; channel 3n+c is colour c of output n
	function automatic ldl_gs_t gs_field(input logic [COMMON_W-1:0] v, input int ch);
		gs_field = v[ch*GS_W +: GS_W];
	endfunction : gs_field

	// Correction value of one channel, same channel order as the grayscale
	function automatic ldl_dot_t dot_field(input logic [COR_W-1:0] v, input int ch);
		dot_field = v[DOT_LSB + ch*DOT_W +: DOT_W];
	endfunction : dot_field

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [PIN_N-1:0] pins_raw;  // All pins, one lane each
	logic [PIN_N-1:0] pins_lvl;  // Settled levels
	logic [PIN_N-1:0] pins_rise; // Rising edges of the settled levels

	// Data travels through the same depth as its clock, so the skew stays small
	// Pin pulses shorter than one clock period can fall between samples and be lost
	assign pins_raw[PIN_PWM_CLK] = i_pwm_serial_clock;
	assign pins_raw[PIN_PWM_IN]  = i_pwm_serial_in;
	assign pins_raw[PIN_STROBE]  = i_pwm_latch_strobe;
	assign pins_raw[PIN_COR_CLK] = i_correction_serial_clock;
	assign pins_raw[PIN_COR_IN]  = i_correction_serial_in;
	assign pins_raw[PIN_BLANK_N] = i_output_blank_n;

	ldl_pin_sync #(
		.WIDTH (PIN_N)
	) u_pin_sync (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_async   (pins_raw),
		.o_level   (pins_lvl),
		.o_rise    (pins_rise)
	);

	logic pwm_clk_rise; // Serial clock edge seen
	logic pwm_in_lvl;   // Serial data at that edge
	logic strobe_lvl;   // Strobe level
	logic strobe_rise;  // Strobe rising edge
	logic cor_clk_rise; // Correction clock edge seen
	logic cor_in_lvl;   // Correction data at that edge
	logic blank_n_lvl;  // Blanking, low forces outputs off

	assign pwm_clk_rise = pins_rise[PIN_PWM_CLK];
	assign pwm_in_lvl   = pins_lvl[PIN_PWM_IN];
	assign strobe_lvl   = pins_lvl[PIN_STROBE];
	assign strobe_rise  = pins_rise[PIN_STROBE];
	assign cor_clk_rise = pins_rise[PIN_COR_CLK];
	assign cor_in_lvl   = pins_lvl[PIN_COR_IN];
	assign blank_n_lvl  = pins_lvl[PIN_BLANK_N];

	////////////////////////////////////////////////////////////////////////////////
	// State

	ldl_state_s q; // Registered state
	ldl_state_s d; // Next state

	// Next-state logic; later assignments win where two paths meet
	always_comb begin
		d            = q;
		d.xfer_pulse = 1'b0;

		// Remember which latch the next strobe will load
		if (pwm_clk_rise) begin
			d.strobe_at_clk = strobe_lvl;
		end

		// Automatic transfer after the correction clock has gone quiet
		unique case (q.xfer)
			XFER_IDLE: begin
				d.cnt = q.cnt;
			end
			XFER_WAIT: begin
				if (q.cnt == CNT_LAST) begin
					d.cor_latch  = q.cor_shift;
					d.xfer       = XFER_IDLE;
					d.xfer_pulse = 1'b1;
				end else begin
					d.cnt = q.cnt + 1'b1;
				end
			end
		endcase

		// Strobe edge loads a latch; a serial clock edge in the same cycle does not shift
		if (strobe_rise) begin
			if (q.strobe_at_clk) begin
				// Correction path: latch low bits, user bits into shift register
				d.cor_latch[COR_COPY_TOP:0]     = q.common[COR_COPY_TOP:0];
				d.cor_shift[COR_W-1:USER_LSB]   = q.common[COR_W-1:USER_LSB];
				// Old latch contents go to the top so they leave first on the output
				d.common[COMMON_W-1:READBACK_LSB] = q.cor_latch;
			end else begin
				d.gs_latch = q.common;
			end
		end else if (pwm_clk_rise) begin
			d.common = {q.common[COMMON_W-2:0], pwm_in_lvl};
		end

		// Correction port shifting restarts the transfer timer
		if (cor_clk_rise) begin
			d.cor_shift = {q.cor_shift[COR_W-2:0], cor_in_lvl};
			d.xfer      = XFER_WAIT;
			d.cnt       = '0;
		end

		// Only control state is reset; data holds whatever it had
		if (i_sys_rst) begin
			d.strobe_at_clk = 1'b0;
			d.xfer          = XFER_IDLE;
			d.cnt           = '0;
			d.xfer_pulse    = 1'b0;
		end
	end

	// State register
	always_ff @(posedge i_clk) begin
		q <= d;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	// Serial outputs straight from the register MSBs
	assign o_pwm_serial_out        = q.common[COMMON_W-1];
	assign o_correction_serial_out = q.cor_shift[COR_W-1];

	// Per-channel values come straight from the latches, so a new frame acts at once
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
			assign o_grayscale_value[ch]       = gs_field(q.gs_latch, ch);
			assign o_per_output_correction[ch] = dot_field(q.cor_latch, ch);
		end
	endgenerate

	// Group fields
	genvar gr;
	generate
		for (gr = 0; gr < GROUPS; gr++) begin : g_group
			assign o_group_brightness[gr] = q.cor_latch[BRIGHTNESS_FIELD_LSB + gr*BRIGHTNESS_FIELD_W +: BRIGHTNESS_FIELD_W];
			assign o_correction_range[gr] = q.cor_latch[RANGE_LSB + gr];
		end
	endgenerate

	assign o_function_bits      = q.cor_latch[FUNCTION_FIELD_LSB +: FUNCTION_FIELD_W];
	assign o_user_bits          = q.cor_latch[USER_LSB +: USER_W];
	assign o_correction_updated = q.xfer_pulse;

	// Blanking gates every driver; it also reads low during reset
	assign o_outputs_on = blank_n_lvl;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	// Strobe edges that load each latch
	sequence s_gs_write;
		strobe_rise && !q.strobe_at_clk;
	endsequence

	sequence s_cor_write;
		strobe_rise && q.strobe_at_clk;
	endsequence

	sequence s_shift;
		pwm_clk_rise && !strobe_rise;
	endsequence

	// Timer at its last count, about to copy the correction shift register
	sequence s_xfer_last;
		q.xfer == XFER_WAIT && q.cnt == CNT_LAST;
	endsequence

	// Serial shift moves every bit one place up
	AST_SHIFT_IN: assert property (
		s_shift |=> q.common == {$past(q.common[COMMON_W-2:0]), $past(pwm_in_lvl)})
		else $error("common register did not shift");

	// Serial output follows the bit that was just below the MSB
	AST_SERIAL_OUT: assert property (
		s_shift |=> o_pwm_serial_out == $past(q.common[COMMON_W-2]))
		else $error("serial output not from shifted MSB");

	// Grayscale latch takes the whole frame
	AST_GS_LATCH: assert property (
		s_gs_write |=> q.gs_latch == $past(q.common))
		else $error("grayscale latch not loaded");

	// Channel 2 and the last channel land at their fixed places
	AST_GS_MAP: assert property (
		s_gs_write |=> o_grayscale_value[2] == $past(q.common[35:24])
			&& o_grayscale_value[CHANNELS-1] == $past(q.common[287:276]))
		else $error("grayscale channel mapping wrong");

	// Correction write from the common path
	AST_COR_LATCH: assert property (
		s_cor_write ##0 !cor_clk_rise |=> q.cor_latch[198:0] == $past(q.common[198:0])
			&& q.cor_shift[215:199] == $past(q.common[215:199]))
		else $error("correction write from common path wrong");

	// Old latch contents become readable at the top of the common register
	AST_READBACK: assert property (
		s_cor_write |=> q.common[COMMON_W-1:READBACK_LSB] == $past(q.cor_latch))
		else $error("latch read-back not loaded");

	// Range bits track the function field after a correction write
	AST_RANGE: assert property (
		s_cor_write ##0 (q.xfer == XFER_IDLE) |=> o_correction_range == $past(q.common[194:192]))
		else $error("correction range bits wrong");

	// Correction port shift
	AST_COR_SHIFT: assert property (
		cor_clk_rise |=> q.cor_shift == {$past(q.cor_shift[COR_W-2:0]), $past(cor_in_lvl)}
			&& q.xfer == XFER_WAIT && q.cnt == '0)
		else $error("correction shift or timer restart wrong");

	// Transfer fires only at the last count and copies the shift register
	AST_XFER_TIME: assert property (
		q.xfer_pulse && !$past(strobe_rise) |-> $past(q.cnt) == CNT_LAST
			&& q.cor_latch == $past(q.cor_shift))
		else $error("automatic transfer at wrong time or with wrong data");

	// Timer never runs past its last count
	AST_XFER_BOUND: assert property (
		q.xfer == XFER_WAIT |-> q.cnt <= CNT_LAST)
		else $error("transfer timer overran");

	// Three low samples at the pin switch the outputs off
	AST_BLANK: assert property (
		(!i_output_blank_n) [*3] |-> !o_outputs_on)
		else $error("outputs not forced off by blanking");

	// Strobe level is captured at every serial clock edge
	AST_STROBE_LEVEL: assert property (
		pwm_clk_rise |=> q.strobe_at_clk == $past(strobe_lvl))
		else $error("strobe level not captured at serial clock edge");

	// Timer advances one step per cycle while the correction clock stays quiet
	AST_XFER_COUNT: assert property (
		q.xfer == XFER_WAIT && q.cnt != CNT_LAST && !cor_clk_rise
			|=> q.xfer == XFER_WAIT && q.cnt == $past(q.cnt) + 1'b1)
		else $error("transfer timer did not advance");

	// Last count fires the transfer and the update pulse follows at once
	AST_XFER_PULSE: assert property (
		s_xfer_last ##0 !cor_clk_rise |=> q.xfer == XFER_IDLE && o_correction_updated)
		else $error("transfer did not fire at the last count");

	// An idle timer neither starts on its own nor pulses the update flag
	AST_XFER_QUIET: assert property (
		q.xfer == XFER_IDLE && !cor_clk_rise |=> q.xfer == XFER_IDLE && !o_correction_updated)
		else $error("transfer fired while the timer was idle");

endmodule : ldl_serial_latches

//--- verif/ldl_ctrl_model.sv
////////////////////////////////////////////////////////////////////////////////
// Display controller model: drives both serial links and the latch strobe
module ldl_ctrl_model (
	output logic o_pwm_serial_clock,
	output logic o_pwm_serial_in,
	output logic o_pwm_latch_strobe,
	output logic o_correction_serial_clock,
	output logic o_correction_serial_in
);
	timeunit 1ns;
	timeprecision 100ps;

	localparam realtime HALF = 62.5; // Half of the 125 ns link period

	// Clocks stand still low outside frames
	initial begin
		o_pwm_serial_clock        = 1'b0;
		o_pwm_serial_in           = 1'b0;
		o_pwm_latch_strobe        = 1'b0;
		o_correction_serial_clock = 1'b0;
		o_correction_serial_in    = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shift n bits MSB first; mode 0 latches grayscale, 1 correction, 2 none
	task automatic send_pwm(input logic [287:0] v, input int n, input int mode);
		for (int i = n - 1; i >= 0; i--) begin
			o_pwm_serial_in = v[i];
			if (i == 0 && mode == 1) begin
				o_pwm_latch_strobe = 1'b1; // High at last clock picks correction latch
			end
			#HALF o_pwm_serial_clock = 1'b1;
			#HALF o_pwm_serial_clock = 1'b0;
		end
		// Data line is not held after the frame: show the inverse, not a stale bit
		o_pwm_serial_in = ~o_pwm_serial_in;
		if (mode == 1) begin
			#HALF o_pwm_latch_strobe = 1'b0;
		end
		if (mode != 2) begin
			#HALF o_pwm_latch_strobe = 1'b1; // Bench keeps outputs blanked here
			#HALF o_pwm_latch_strobe = 1'b0;
		end
	endtask : send_pwm

	// Shift a whole correction frame MSB first on the correction link
	task automatic send_cor(input logic [215:0] v);
		for (int i = 215; i >= 0; i--) begin
			o_correction_serial_in = v[i];
			#HALF o_correction_serial_clock = 1'b1;
			#HALF o_correction_serial_clock = 1'b0;
		end
		o_correction_serial_in = ~o_correction_serial_in;
	endtask : send_cor

endmodule : ldl_ctrl_model

//--- verif/ldl_serial_latches_tb_top.sv
module ldl_serial_latches_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import ldl_pkg::*;

	localparam int XFER = 20; // Shortened correction transfer delay

	logic            clk;         // System clock
	logic            sys_rst;     // Synchronous reset
	logic            blank_n;     // Blanking, low forces outputs off
	logic            pclk, pin, strobe, cclk, cin;
	logic            pout, cout, outputs_on, cor_updated;
	ldl_gs_arr_t     gs;
	ldl_dot_arr_t    dot;
	ldl_brightness_field_arr_t brightness_field;
	logic [6:0]      function_field;
	logic [16:0]     user;
	logic [2:0]      cor_range;
	logic [215:0]    cv;          // Frame sent on the correction link
	int              errors  = 0;
	int              checked = 0;

	// Free-running 100 MHz clock
	always #5 clk = ~clk;

	ldl_serial_latches #(.CORR_XFER_CYCLES(XFER)) ldl_serial_latches_inst (
		.i_clk(clk), .i_sys_rst(sys_rst), .i_pwm_serial_clock(pclk),
		.i_pwm_serial_in(pin), .i_pwm_latch_strobe(strobe),
		.i_correction_serial_clock(cclk), .i_correction_serial_in(cin),
		.i_output_blank_n(blank_n), .o_pwm_serial_out(pout),
		.o_correction_serial_out(cout), .o_grayscale_value(gs),
		.o_per_output_correction(dot), .o_group_brightness(brightness_field),
		.o_function_bits(function_field), .o_user_bits(user), .o_correction_range(cor_range),
		.o_outputs_on(outputs_on), .o_correction_updated(cor_updated)
	);

	ldl_ctrl_model ldl_ctrl_model_inst (
		.o_pwm_serial_clock(pclk), .o_pwm_serial_in(pin), .o_pwm_latch_strobe(strobe),
		.o_correction_serial_clock(cclk), .o_correction_serial_in(cin)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : cmp

	// Step past n edges, landing just after the last one
	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cycles

	task automatic give_verdict;
		if (errors == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : give_verdict

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic test_gs_frame;
		logic [287:0] v;
		for (int k = 0; k < 24; k++) v[12*k +: 12] = 12'(k * 12'h0a5 + 12'h30f);
		ldl_ctrl_model_inst.send_pwm(v, 288, 0);
		cycles(1);
		for (int k = 0; k < 24; k++) begin
			cmp("grayscale", 32'(v[12*k +: 12]), 32'(gs[k]));
		end
		cmp("pwm_serial_out", 32'(v[287]), 32'(pout));
	endtask : test_gs_frame

	// Loaded frame first, then unblank and blank again
	task automatic test_blank;
		blank_n = 1'b1;
		cycles(4);
		cmp("outputs_on", 32'h1, 32'(outputs_on));
		blank_n = 1'b0;
		cycles(4);
		cmp("outputs_off", 32'h0, 32'(outputs_on));
	endtask : test_blank

	task automatic test_cor_link;
		int w;
		cv = '0;
		for (int k = 0; k < 24; k++) cv[7*k +: 7] = 7'(k * 5 + 3);
		for (int g = 0; g < 3; g++) cv[168+8*g +: 8] = 8'(8'h5a + g * 8'h33);
		cv[198:192] = 7'h05;
		cv[215:199] = 17'h1abcd;
		ldl_ctrl_model_inst.send_cor(cv);
		cmp("cor_serial_out", 32'(cv[215]), 32'(cout));
		w = 0;
		// Bounded wait for the automatic transfer; also the quiet gap before a strobe
		while (cor_updated !== 1'b1 && w < 200) begin
			cycles(1);
			w++;
		end
		cmp("xfer_delay_ok", 32'h1, 32'(w > XFER - 8 && w < XFER + 2));
		cycles(1);
		cmp("updated_one_cycle", 32'h0, 32'(cor_updated));
		for (int k = 0; k < 24; k++) cmp("dot", 32'(cv[7*k +: 7]), 32'(dot[k]));
		for (int g = 0; g < 3; g++) cmp("brightness_field", 32'(cv[168+8*g +: 8]), 32'(brightness_field[g]));
		cmp("function_field", 32'h05, 32'(function_field));
		cmp("user", 32'h1abcd, 32'(user));
		cmp("range", 32'h5, 32'(cor_range));
	endtask : test_cor_link

	// Correction write through the common register, then read the old latch back
	task automatic test_common_cor;
		logic [287:0] v;
		v = '0;
		for (int k = 0; k < 24; k++) v[7*k +: 7] = 7'(k * 3 + 1);
		for (int g = 0; g < 3; g++) v[168+8*g +: 8] = 8'(8'hc3 - g * 8'h21);
		v[198:192] = 7'h7a;
		v[215:199] = 17'h0f0f0;
		ldl_ctrl_model_inst.send_pwm(v, 288, 1);
		cycles(1);
		for (int k = 0; k < 24; k++) cmp("dot_common", 32'(v[7*k +: 7]), 32'(dot[k]));
		for (int g = 0; g < 3; g++) begin
			cmp("brightness_field_common", 32'(v[168+8*g +: 8]), 32'(brightness_field[g]));
		end
		cmp("range_common", 32'h2, 32'(cor_range));
		cmp("user_kept", 32'h1abcd, 32'(user));
		cmp("cor_shift_user", 32'(v[215]), 32'(cout));
		cmp("readback", 32'(cv[215]), 32'(pout));
		for (int j = 214; j > 210; j--) begin
			ldl_ctrl_model_inst.send_pwm('0, 1, 2);
			cycles(1);
			cmp("readback", 32'(cv[j]), 32'(pout));
		end
	endtask : test_common_cor

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		clk     = 1'b0;
		sys_rst = 1'b1;
		blank_n = 1'b0;
		cycles(3);
		sys_rst = 1'b0;
		cycles(2);
		test_gs_frame();
		test_blank();
		test_cor_link();
		test_common_cor();
		give_verdict();
	end

	// Watchdog: the run needs about 100 us, three times that is allowed
	initial begin
		#300000;
		errors++;
		give_verdict();
	end

endmodule : ldl_serial_latches_tb_top
